// [include/mfs_pkg.sv]
// Shared constants and carrier types for the fail-safe supervisor
package mfs_pkg;

   // Register numbers as seen by the Modbus client
   localparam logic [15:0] A_CONN_TMO  = 16'h0500;
   localparam logic [15:0] A_WD_TMO    = 16'h07D0;
   localparam logic [15:0] A_PATTERN   = 16'h07D2;
   localparam logic [15:0] A_CAUSE     = 16'h07D4;
   localparam logic [15:0] A_COMMAND   = 16'h07D6;
   localparam logic [15:0] A_STATUS    = 16'h1F3C;
   localparam logic [15:0] A_DIAG_STAT = 16'h1F3D;
   localparam logic [15:0] A_DIAG_LOC  = 16'h1F3E;
   localparam logic [15:0] A_IN_WORD   = 16'h1F40;
   localparam logic [15:0] A_OUT_WORD  = 16'h2328;

   // Function codes
   localparam logic [7:0] FC_RD_COILS  = 8'h01;
   localparam logic [7:0] FC_RD_DISCR  = 8'h02;
   localparam logic [7:0] FC_RD_HOLD   = 8'h03;
   localparam logic [7:0] FC_RD_INPUT  = 8'h04;
   localparam logic [7:0] FC_WR_COIL   = 8'h05;
   localparam logic [7:0] FC_WR_REG    = 8'h06;
   localparam logic [7:0] FC_WR_COILS  = 8'h0F;
   localparam logic [7:0] FC_WR_REGS   = 8'h10;
   localparam logic [7:0] FC_RW_REGS   = 8'h17;

   // Exception answers
   localparam logic [7:0] EXC_NONE     = 8'h00;
   localparam logic [7:0] EXC_FUNCTION = 8'h01;
   localparam logic [7:0] EXC_ADDRESS  = 8'h02;
   localparam logic [7:0] EXC_VALUE    = 8'h03;

   // Failure causes
   localparam logic [15:0] CAUSE_NONE   = 16'h0000;
   localparam logic [15:0] CAUSE_XFER   = 16'h0007;
   localparam logic [15:0] CAUSE_HOST   = 16'h0008;
   localparam logic [15:0] CAUSE_USER   = 16'h0009;
   localparam logic [15:0] CAUSE_ABORT  = 16'h000A;
   localparam logic [15:0] CAUSE_INIT   = 16'h000B;
   localparam logic [15:0] CAUSE_WDOG   = 16'h000C;
   localparam logic [15:0] CAUSE_CMON   = 16'h000D;

   // Fault output patterns
   localparam logic [15:0] PAT_LOW  = 16'h0000;
   localparam logic [15:0] PAT_HIGH = 16'h0001;
   localparam logic [15:0] PAT_HOLD = 16'h0002;

   // Command bits, status bits, timeout limits
   localparam int          CMD_FORCE_BIT = 4;
   localparam int          CMD_ACK_BIT   = 5;
   localparam int          CMD_WARN_BIT  = 7;
   localparam int          ST_WARN_BIT   = 0;
   localparam int          ST_FAIL_BIT   = 1;
   localparam logic [15:0] TMO_MIN_MS    = 16'h00C8;
   localparam logic [15:0] TMO_MAX_MS    = 16'hFDE8;
   localparam logic [15:0] TMO_RESET     = 16'h0000;
   localparam logic [15:0] OUT_RESET     = 16'h0000;

   // Timing: one millisecond tick derived from the 50 ns clock
   localparam int TICK_NS       = 1000000;
   localparam int CLK_NS        = 50;
   localparam int MS_CYCLES_DEF = TICK_NS / CLK_NS;
   localparam int NCONN_DEF     = 8;
   localparam int CONN_W        = 3;

   // One register access from the Modbus/TCP stack
   typedef struct packed {
      logic [CONN_W-1:0] conn;
      logic [7:0]        fc;
      logic              write;
      logic [15:0]       addr;
      logic [3:0]        bit_idx;
      logic [15:0]       wdata;
   } mfs_req_type;

   // Answer to one access
   typedef struct packed {
      logic [15:0] rdata;
      logic [7:0]  exc;
   } mfs_rsp_type;

endpackage

// [rtl/mfs_supervisor.sv]
// Fail-safe supervisor: Modbus register front end, watchdogs and output substitution
// How it works
// - In auto mode, a valid output word write clears the failure flag.
// - In manual mode the failure stays until command or web acknowledge.
// - Acknowledge mode comes only from web management, never from a register.
// - On failure every output takes the configured substitute value.
// - Eight connections, each may reach any register on its own.
// - Function codes 1,2,3,4,5,6,15,16,23 are accepted.
// - Both timeout words are read and written with codes 3,4,6,16,23.
// - Pattern word is read/write; cause, status, diagnostic words read-only.
// - Input word read-only; output word read/write; bit writes only to output.
// - Writes to read-only registers change nothing and answer exception 2.
// - Connection timeout is 0 (off) or 200..65000 ms.
// - New connection timeout applies after a function runs on that connection.
// - Watchdog timeout is 0 (off) or 200..65000 ms.
// - Pattern 0 drives low, 1 drives high, 2 holds last outputs.
// - Cause codes 7..0xD report the reason of the failure.
// - Command word is write-only; more than one set bit is an error.
// - Command bit 4 forces failure, bit 5 acknowledges in manual mode, bit 7 clears warning.
// - Watchdog starts at first output word write, restarts on output word writes, never on reads.
// - Watchdog expiry substitutes outputs and sets status bit 1.
// - Acknowledge restarts the watchdog.
// - Output writes are stored while failed and applied after the failure clears.
module mfs_supervisor #(
   parameter int MS_CYCLES = mfs_pkg::MS_CYCLES_DEF,
   parameter int NCONN     = mfs_pkg::NCONN_DEF
) (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // Register access from the Modbus/TCP stack
   input  wire logic                 req_valid,
   input  wire mfs_pkg::mfs_req_type req,
   output logic                      rsp_valid,
   output mfs_pkg::mfs_rsp_type      rsp,
   // Connection and network events
   input  wire logic [NCONN-1:0]     conn_close,
   input  wire logic [NCONN-1:0]     conn_abort,
   input  wire logic                 xfer_timeout,
   input  wire logic                 host_timeout,
   input  wire logic                 init_error,
   // Web management
   input  wire logic                 wm_manual_ack,
   input  wire logic                 wm_ack,
   // I/O diagnostics and pins
   input  wire logic [15:0]          diag_status_in,
   input  wire logic [15:0]          diag_loc_in,
   input  wire logic [15:0]          din_pin,
   output logic [15:0]               dout,
   output logic                      net_fail,
   output logic                      io_warn
);

   localparam int CW = mfs_pkg::CONN_W;

   // Configuration and process data registers
   logic [15:0] cmt_ff, nxt_cmt, wdt_ff, nxt_wdt, pat_ff, nxt_pat;
   logic [15:0] out_ff, nxt_out;
   logic        warn_ff, nxt_warn;
   // Failure state
   logic        fail_ff, nxt_fail;
   logic [15:0] cause_ff, nxt_cause;
   // Watchdog and tick
   logic        wd_run_ff, nxt_wd_run;
   logic [15:0] wd_cnt_ff, nxt_wd_cnt;
   logic [31:0] tick_cnt_ff, nxt_tick_cnt;
   logic        tick, wd_exp;
   // Answer and pin registers
   logic                 rsp_valid_ff;
   mfs_pkg::mfs_rsp_type rsp_ff, nxt_rsp;
   logic [15:0]          dout_ff, nxt_dout;
   logic [15:0]          din_s1_ff, din_s2_ff;
   // Decode results
   logic        rd_op, wr_op, bit_op, fc_ok, val_ok;
   logic [7:0]  exc;
   logic [15:0] word;
   logic        acc_wr, wr_cmt, wr_wdt, wr_pat, wr_out, wr_cmd;
   logic        cmd_force, cmd_ack, cmd_warn, ack;
   logic [NCONN-1:0] conn_exp;

   // Classify the function code
   always_comb begin
      rd_op  = 1'b0;
      wr_op  = 1'b0;
      bit_op = 1'b0;
      fc_ok  = 1'b1;
      case (req.fc)
         mfs_pkg::FC_RD_COILS, mfs_pkg::FC_RD_DISCR: begin
            rd_op  = 1'b1;
            bit_op = 1'b1;
         end
         mfs_pkg::FC_RD_HOLD, mfs_pkg::FC_RD_INPUT: rd_op = 1'b1;
         mfs_pkg::FC_WR_COIL, mfs_pkg::FC_WR_COILS: begin
            wr_op  = 1'b1;
            bit_op = 1'b1;
         end
         mfs_pkg::FC_WR_REG, mfs_pkg::FC_WR_REGS: wr_op = 1'b1;
         mfs_pkg::FC_RW_REGS: begin
            rd_op = ~req.write;
            wr_op = req.write;
         end
         default: fc_ok = 1'b0;
      endcase
   end

   // Address decode, access check and read data; one answer per word or bit
   always_comb begin
      exc    = mfs_pkg::EXC_NONE;
      word   = 16'h0000;
      val_ok = 1'b1;
      case (req.addr)
         mfs_pkg::A_CONN_TMO, mfs_pkg::A_WD_TMO: begin
            word   = (req.addr == mfs_pkg::A_CONN_TMO) ? cmt_ff : wdt_ff;
            if (bit_op) exc = mfs_pkg::EXC_ADDRESS;
            val_ok = (req.wdata == 16'h0000) || ((req.wdata >= mfs_pkg::TMO_MIN_MS) &&
                     (req.wdata <= mfs_pkg::TMO_MAX_MS));
         end
         mfs_pkg::A_PATTERN: begin
            word   = pat_ff;
            if (bit_op) exc = mfs_pkg::EXC_ADDRESS;
            val_ok = (req.wdata <= mfs_pkg::PAT_HOLD);
         end
         mfs_pkg::A_CAUSE, mfs_pkg::A_STATUS, mfs_pkg::A_DIAG_STAT, mfs_pkg::A_DIAG_LOC: begin
            case (req.addr)
               mfs_pkg::A_CAUSE:     word = cause_ff;
               mfs_pkg::A_STATUS:    word = {14'h0000, fail_ff, warn_ff};
               mfs_pkg::A_DIAG_STAT: word = diag_status_in;
               default:              word = diag_loc_in;
            endcase
            if (bit_op || wr_op) exc = mfs_pkg::EXC_ADDRESS;
         end
         mfs_pkg::A_COMMAND: begin
            if (bit_op || rd_op) exc = mfs_pkg::EXC_ADDRESS;
            val_ok = $onehot(req.wdata);
         end
         mfs_pkg::A_IN_WORD: begin
            word = din_s2_ff;
            if (wr_op) exc = mfs_pkg::EXC_ADDRESS;
         end
         mfs_pkg::A_OUT_WORD: word = out_ff;
         default: exc = mfs_pkg::EXC_ADDRESS;
      endcase
      if (!fc_ok) begin
         exc = mfs_pkg::EXC_FUNCTION;
      end else if (exc == mfs_pkg::EXC_NONE && wr_op && !val_ok) begin
         exc = mfs_pkg::EXC_VALUE;
      end
      if (bit_op) begin
         word = {15'h0000, word[req.bit_idx]};
      end
   end

   // Write strobes; any connection reaches any register the same way
   assign acc_wr    = req_valid && wr_op && (exc == mfs_pkg::EXC_NONE);
   assign wr_cmt    = acc_wr && (req.addr == mfs_pkg::A_CONN_TMO);
   assign wr_wdt    = acc_wr && (req.addr == mfs_pkg::A_WD_TMO);
   assign wr_pat    = acc_wr && (req.addr == mfs_pkg::A_PATTERN);
   assign wr_out    = acc_wr && (req.addr == mfs_pkg::A_OUT_WORD);
   assign wr_cmd    = acc_wr && (req.addr == mfs_pkg::A_COMMAND);
   assign cmd_force = wr_cmd && req.wdata[mfs_pkg::CMD_FORCE_BIT];
   assign cmd_ack   = wr_cmd && req.wdata[mfs_pkg::CMD_ACK_BIT];
   assign cmd_warn  = wr_cmd && req.wdata[mfs_pkg::CMD_WARN_BIT];
   // Acknowledge mode is a web-only input, no register reaches it
   assign ack = wm_manual_ack ? (cmd_ack || wm_ack) : wr_out;

   // Configuration registers; output data is stored even while failed
   always_comb begin
      nxt_cmt  = wr_cmt ? req.wdata : cmt_ff;
      nxt_wdt  = wr_wdt ? req.wdata : wdt_ff;
      nxt_pat  = wr_pat ? req.wdata : pat_ff;
      nxt_out  = out_ff;
      if (wr_out) begin
         if (bit_op) begin
            nxt_out[req.bit_idx] = req.wdata[0];
         end else begin
            nxt_out = req.wdata;
         end
      end
      // Diagnostic level wins over the clear so a live fault is not lost
      nxt_warn = (|diag_status_in) || (warn_ff && !cmd_warn);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cmt_ff  <= mfs_pkg::TMO_RESET;
         wdt_ff  <= mfs_pkg::TMO_RESET;
         pat_ff  <= mfs_pkg::PAT_LOW;
         out_ff  <= mfs_pkg::OUT_RESET;
         warn_ff <= 1'b0;
      end else begin
         cmt_ff  <= nxt_cmt;
         wdt_ff  <= nxt_wdt;
         pat_ff  <= nxt_pat;
         out_ff  <= nxt_out;
         warn_ff <= nxt_warn;
      end
   end

   // Millisecond tick and process data watchdog
   always_comb begin
      tick         = (tick_cnt_ff == 32'(MS_CYCLES - 1));
      nxt_tick_cnt = tick ? 32'h0000_0000 : tick_cnt_ff + 32'h0000_0001;
      wd_exp       = 1'b0;
      nxt_wd_run   = wd_run_ff;
      nxt_wd_cnt   = wd_cnt_ff;
      if (wd_run_ff && tick) begin
         if (wd_cnt_ff >= wdt_ff - 16'h0001) begin
            wd_exp     = 1'b1;
            nxt_wd_run = 1'b0;
         end else begin
            nxt_wd_cnt = wd_cnt_ff + 16'h0001;
         end
      end
      // Only output word writes and acknowledges retrigger; reads never do
      if (wr_out || (fail_ff && ack)) begin
         nxt_wd_run = 1'b1;
         nxt_wd_cnt = 16'h0000;
      end
      if (nxt_wdt == 16'h0000) begin
         nxt_wd_run = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tick_cnt_ff <= 32'h0000_0000;
         wd_run_ff   <= 1'b0;
         wd_cnt_ff   <= 16'h0000;
      end else begin
         tick_cnt_ff <= nxt_tick_cnt;
         wd_run_ff   <= nxt_wd_run;
         wd_cnt_ff   <= nxt_wd_cnt;
      end
   end

   // Per-connection monitoring; each connection latches the timeout when served
   genvar g;
   generate
      for (g = 0; g < NCONN; g++) begin : g_conn
         logic        act_ff, nxt_act;
         logic [15:0] tmo_ff, nxt_tmo, cnt_ff, nxt_cnt;
         logic        exp_c;
         always_comb begin
            nxt_act = act_ff;
            nxt_tmo = tmo_ff;
            nxt_cnt = cnt_ff;
            exp_c   = 1'b0;
            if (act_ff && tick && (tmo_ff != 16'h0000)) begin
               if (cnt_ff >= tmo_ff - 16'h0001) begin
                  exp_c   = 1'b1;
                  nxt_act = 1'b0;
               end else begin
                  nxt_cnt = cnt_ff + 16'h0001;
               end
            end
            if (conn_close[g] || conn_abort[g]) begin
               nxt_act = 1'b0;
            end
            if (req_valid && (req.conn == CW'(g))) begin
               nxt_act = 1'b1;
               nxt_tmo = nxt_cmt;
               nxt_cnt = 16'h0000;
            end
         end
         assign conn_exp[g] = exp_c;
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               act_ff <= 1'b0;
               tmo_ff <= mfs_pkg::TMO_RESET;
               cnt_ff <= 16'h0000;
            end else begin
               act_ff <= nxt_act;
               tmo_ff <= nxt_tmo;
               cnt_ff <= nxt_cnt;
            end
         end
      end
   endgenerate

   // Failure flag and cause; a new failure in the acknowledge cycle wins
   always_comb begin
      nxt_cause = cause_ff;
      if (wd_exp) nxt_cause = mfs_pkg::CAUSE_WDOG;
      else if (|conn_exp) nxt_cause = mfs_pkg::CAUSE_CMON;
      else if (|conn_abort) nxt_cause = mfs_pkg::CAUSE_ABORT;
      else if (host_timeout) nxt_cause = mfs_pkg::CAUSE_HOST;
      else if (xfer_timeout) nxt_cause = mfs_pkg::CAUSE_XFER;
      else if (init_error) nxt_cause = mfs_pkg::CAUSE_INIT;
      else if (cmd_force) nxt_cause = mfs_pkg::CAUSE_USER;
      nxt_fail = wd_exp || (|conn_exp) || (|conn_abort) || host_timeout ||
                 xfer_timeout || init_error || cmd_force || (fail_ff && !ack);
   end

   // Substitute or live outputs; hold mode keeps the last driven pattern
   always_comb begin
      nxt_dout = out_ff;
      if (fail_ff) begin
         case (pat_ff)
            mfs_pkg::PAT_LOW:  nxt_dout = 16'h0000;
            mfs_pkg::PAT_HIGH: nxt_dout = 16'hFFFF;
            default:           nxt_dout = dout_ff;
         endcase
      end
      nxt_rsp.rdata = word;
      nxt_rsp.exc   = exc;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fail_ff      <= 1'b0;
         cause_ff     <= mfs_pkg::CAUSE_NONE;
         dout_ff      <= mfs_pkg::OUT_RESET;
         rsp_valid_ff <= 1'b0;
         rsp_ff       <= '0;
         din_s1_ff    <= 16'h0000;
         din_s2_ff    <= 16'h0000;
      end else begin
         fail_ff      <= nxt_fail;
         cause_ff     <= nxt_cause;
         dout_ff      <= nxt_dout;
         rsp_valid_ff <= req_valid;
         rsp_ff       <= nxt_rsp;
         din_s1_ff    <= din_pin;
         din_s2_ff    <= din_s1_ff;
      end
   end

   // Outputs straight from flip-flops
   assign rsp_valid = rsp_valid_ff;
   assign rsp       = rsp_ff;
   assign dout      = dout_ff;
   assign net_fail  = fail_ff;
   assign io_warn   = warn_ff;

endmodule

// [tb/mfs_supervisor_sva.sv]
// Assertion checker on the supervisor ports, bound at the foot
module mfs_supervisor_chk #(
   parameter int MS_CYCLES = 4,
   parameter int NCONN     = 8
) (
   // Clock and reset
   input wire logic                 clk,
   input wire logic                 rst_n,
   // Register access
   input wire logic                 req_valid,
   input wire mfs_pkg::mfs_req_type req,
   input wire logic                 rsp_valid,
   input wire mfs_pkg::mfs_rsp_type rsp,
   // Events and web management
   input wire logic [NCONN-1:0]     conn_abort,
   input wire logic                 xfer_timeout,
   input wire logic                 host_timeout,
   input wire logic                 init_error,
   input wire logic                 wm_manual_ack,
   input wire logic                 wm_ack,
   // Pins and flags
   input wire logic [15:0]          diag_status_in,
   input wire logic [15:0]          dout,
   input wire logic                 net_fail,
   input wire logic                 io_warn
);
   logic evt, wr_cmd, fc_ok;
   // Decodes kept outside the properties so each stays short
   assign evt = xfer_timeout || host_timeout || init_error || (|conn_abort);
   assign wr_cmd = req_valid && req.fc == 8'h06 && req.addr == 16'h07D6;
   assign fc_ok = req.fc inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0F, 8'h10, 8'h17};
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   rsp_pulse_a: assert property (req_valid |=> rsp_valid)
      else $error("request not answered");
   no_rsp_a: assert property (!req_valid |=> !rsp_valid)
      else $error("answer without request");
   bad_fc_a: assert property (req_valid && !fc_ok |=> rsp.exc == 8'h01)
      else $error("unsupported code accepted");
   ro_write_a: assert property (req_valid && req.fc == 8'h06
         && req.addr inside {16'h07D4, 16'h1F3C, 16'h1F3E, 16'h1F40} |=> rsp.exc == 8'h02)
      else $error("read-only write not refused");
   multi_cmd_a: assert property (wr_cmd && !$onehot(req.wdata)
         |=> rsp.exc == 8'h03 && !$rose(net_fail))
      else $error("multi-bit command acted");
   force_fail_a: assert property (wr_cmd && req.wdata == 16'h0010 |=> ##[0:1] net_fail)
      else $error("force command ignored");
   event_fail_a: assert property (evt |=> ##[0:1] net_fail)
      else $error("event did not fail");
   hold_out_a: assert property (net_fail [*3] |-> $stable(dout))
      else $error("outputs moved while failed");
   auto_ack_a: assert property (!wm_manual_ack && wm_ack && net_fail && !req_valid && !evt
         |=> net_fail)
      else $error("web ack acted in auto mode");
   manual_keep_a: assert property (wm_manual_ack && net_fail && !req_valid && !wm_ack
         && !$past(req_valid) && !$past(wm_ack) |=> net_fail)
      else $error("manual failure dropped");
   status_rd_a: assert property (req_valid && req.fc == 8'h03 && req.addr == 16'h1F3C
         |=> rsp.rdata == {14'h0000, $past(net_fail), $past(io_warn)})
      else $error("status word wrong");
   warn_set_a: assert property (|diag_status_in |=> ##[0:1] io_warn)
      else $error("warning not raised");
   // Main scenarios
   c_force: cover property (wr_cmd && req.wdata == 16'h0010);
   c_ack: cover property (wr_cmd && req.wdata == 16'h0020 && net_fail);
   c_expire: cover property ($rose(net_fail) && !evt && !req_valid);
endmodule

bind mfs_supervisor mfs_supervisor_chk #(.MS_CYCLES(MS_CYCLES), .NCONN(NCONN)) chk_u (
   .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid),
   .rsp(rsp), .conn_abort(conn_abort), .xfer_timeout(xfer_timeout),
   .host_timeout(host_timeout), .init_error(init_error), .wm_manual_ack(wm_manual_ack),
   .wm_ack(wm_ack), .diag_status_in(diag_status_in), .dout(dout), .net_fail(net_fail),
   .io_warn(io_warn));

// [tb/mfs_client_model.sv]
// Modbus/TCP client model issuing single register accesses
module mfs_client_model (
   // Clock
   input  wire logic                 clk,
   // Requests and answers
   output logic                      req_valid,
   output mfs_pkg::mfs_req_type      req,
   input  wire logic                 rsp_valid,
   input  wire mfs_pkg::mfs_rsp_type rsp
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle at time zero
   initial begin
      req_valid = 1'b0;
      req = '1;
   end
   // Caller picks values; bad ones only where a refusal is wanted
   task automatic access(input logic [2:0] conn, input logic [7:0] fc, input logic wr,
                         input logic [15:0] a, input logic [3:0] bi, input logic [15:0] d,
                         output mfs_pkg::mfs_rsp_type ans, output bit ok);
      ok = 1'b0;
      ans = '0;
      @(posedge clk);
      req_valid <= 1'b1;
      req <= '{conn, fc, wr, a, bi, d};
      @(posedge clk);
      req_valid <= 1'b0;
      // Released fields turn over, so stale data never looks live
      req <= mfs_pkg::mfs_req_type'(~req);
      for (int n = 0; n < 4 && !ok; n++) begin
         #1;
         ok = rsp_valid === 1'b1;
         ans = rsp;
         if (!ok) @(posedge clk);
      end
   endtask
endmodule

// [tb/tb.sv]
// Self-checking bench for the fail-safe supervisor
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int MSC = 4;
   logic                 clk, rst_n, req_valid, rsp_valid, xfer_timeout, host_timeout;
   logic                 init_error, wm_manual_ack, wm_ack, net_fail, io_warn, ph;
   logic [7:0]           conn_abort;
   logic [15:0]          diag_status_in, diag_loc_in, din_pin, dout;
   logic [2:0]           cid;
   logic [3:0]           bi;
   mfs_pkg::mfs_req_type req;
   mfs_pkg::mfs_rsp_type rsp, ans;
   int                   n_errors, checks_done;
   logic [15:0]          tv [5] = '{16'h0000, 16'h00C8, 16'hFDE8, 16'h00C7, 16'hFDE9};
   logic [15:0]          ta [2] = '{16'h0500, 16'h07D0};
   logic [15:0]          ro [5] = '{16'h07D4, 16'h1F3C, 16'h1F3D, 16'h1F3E, 16'h1F40};
   logic [15:0]          pe [3] = '{16'h0000, 16'hFFFF, 16'h3C3C};
   logic [15:0]          ec [4] = '{16'h0007, 16'h0008, 16'h000B, 16'h000A};

   mfs_supervisor #(.MS_CYCLES(MSC), .NCONN(8)) dut_u (
      .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid),
      .rsp(rsp), .conn_close(8'h00), .conn_abort(conn_abort), .xfer_timeout(xfer_timeout),
      .host_timeout(host_timeout), .init_error(init_error), .wm_manual_ack(wm_manual_ack),
      .wm_ack(wm_ack), .diag_status_in(diag_status_in), .diag_loc_in(diag_loc_in),
      .din_pin(din_pin), .dout(dout), .net_fail(net_fail), .io_warn(io_warn));
   mfs_client_model client_u (.clk(clk), .req_valid(req_valid), .req(req),
      .rsp_valid(rsp_valid), .rsp(rsp));

   // Verdict and end of run
   task automatic wrap_up();
      if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // One access; a lost answer ends the run
   task automatic acc(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] d,
                      input logic [7:0] exc);
      bit ok;
      client_u.access(cid, fc, ph, a, bi, d, ans, ok);
      if (!ok) begin
         n_errors++;
         $display("mismatch at %0t: no answer", $time);
         wrap_up();
      end else begin
         chk({8'h00, ans.exc}, {8'h00, exc}, "exception");
      end
   endtask
   task automatic rd(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] exp);
      acc(fc, a, 16'h0000, 8'h00);
      chk(ans.rdata, exp, "read");
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic flag(input logic e);
      #1;
      chk({15'h0000, net_fail}, {15'h0000, e}, "failure flag");
   endtask
   task automatic dchk(input logic [15:0] e);
      #1;
      chk(dout, e, "outputs");
   endtask
   // Bounded wait for the failure flag
   task automatic wait_fail(input int max);
      for (int n = 0; n < max && net_fail !== 1'b1; n++) @(posedge clk);
      flag(1'b1);
      // A spent bound is a mismatch and closes the run
      if (net_fail !== 1'b1) wrap_up();
   endtask
   // One-cycle pulse on event k (4 is the web acknowledge)
   task automatic ev(input int k);
      int j;
      j = k;
      repeat (2) begin
         @(posedge clk);
         xfer_timeout <= (j == 0);
         host_timeout <= (j == 1);
         init_error <= (j == 2);
         conn_abort <= {7'h00, j == 3};
         wm_ack <= (j == 4);
         j = 9;
      end
   endtask

   // Clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Hang guard
   initial begin
      idle(20000);
      n_errors++;
      $display("mismatch at %0t: run did not finish", $time);
      wrap_up();
   end
   // Main sequence
   initial begin
      {rst_n, xfer_timeout, host_timeout, init_error, wm_manual_ack, wm_ack, ph} = '0;
      {conn_abort, diag_status_in, diag_loc_in, cid, bi} = '0;
      din_pin = 16'hA55A;
      idle(12);
      rst_n <= 1'b1;
      rd(8'h03, 16'h07D2, 16'h0000);
      rd(8'h04, 16'h1F40, 16'hA55A);
      foreach (tv[i]) for (int a = 0; a < 2; a++) begin
         acc(i[0] ? 8'h10 : 8'h06, ta[a], tv[i], (i < 3) ? 8'h00 : 8'h03);
         rd(a ? 8'h17 : 8'h04, ta[a], (i < 3) ? tv[i] : 16'hFDE8);
      end
      ph = 1'b1;
      acc(8'h17, 16'h0500, 16'h0000, 8'h00);
      acc(8'h17, 16'h07D0, 16'h0000, 8'h00);
      ph = 1'b0;
      foreach (ro[i]) acc(8'h06, ro[i], 16'h0001, 8'h02);
      rd(8'h03, 16'h07D4, 16'h0000);
      acc(8'h03, 16'h07D6, 16'h0000, 8'h02);
      acc(8'h07, 16'h2328, 16'h0000, 8'h01);
      acc(8'h03, 16'h1234, 16'h0000, 8'h02);
      acc(8'h05, 16'h07D2, 16'h0001, 8'h02);
      acc(8'h06, 16'h2328, 16'h00FF, 8'h00);
      bi = 4'h8;
      acc(8'h05, 16'h2328, 16'h0001, 8'h00);
      bi = 4'hF;
      acc(8'h0F, 16'h2328, 16'h0001, 8'h00);
      rd(8'h01, 16'h2328, 16'h0001);
      bi = 4'h1;
      rd(8'h02, 16'h1F40, 16'h0001);
      for (int c = 0; c < 8; c++) begin
         cid = c[2:0];
         rd(8'h03, 16'h2328, 16'h81FF);
      end
      cid = 3'h0;
      dchk(16'h81FF);
      foreach (pe[p]) begin
         acc(8'h06, 16'h07D2, p[15:0], 8'h00);
         acc(8'h06, 16'h07D6, 16'h0010, 8'h00);
         idle(3);
         dchk(pe[p]);
         rd(8'h04, 16'h07D4, 16'h0009);
         ev(4);
         flag(1'b1);
         acc(8'h06, 16'h2328, 16'h3C3C, 8'h00);
         idle(2);
         flag(1'b0);
         dchk(16'h3C3C);
      end
      acc(8'h06, 16'h07D2, 16'h0003, 8'h03);
      foreach (ec[k]) begin
         ev(k);
         idle(2);
         flag(1'b1);
         rd(8'h03, 16'h07D4, ec[k]);
         acc(8'h06, 16'h2328, 16'h3C3C, 8'h00);
      end
      // Manual acknowledge
      idle(1);
      wm_manual_ack <= 1'b1;
      acc(8'h06, 16'h07D6, 16'h0010, 8'h00);
      acc(8'h06, 16'h2328, 16'h5A5A, 8'h00);
      idle(2);
      flag(1'b1);
      dchk(16'h3C3C);
      acc(8'h06, 16'h07D6, 16'h0030, 8'h03);
      acc(8'h10, 16'h07D6, 16'h0000, 8'h03);
      flag(1'b1);
      acc(8'h06, 16'h07D6, 16'h0020, 8'h00);
      idle(2);
      flag(1'b0);
      dchk(16'h5A5A);
      acc(8'h06, 16'h07D6, 16'h0010, 8'h00);
      ev(4);
      idle(2);
      flag(1'b0);
      wm_manual_ack <= 1'b0;
      // Warning and diagnostics
      idle(1);
      diag_status_in <= 16'h0010;
      diag_loc_in <= 16'h0002;
      idle(3);
      chk({15'h0000, io_warn}, 16'h0001, "warning pin");
      rd(8'h03, 16'h1F3C, 16'h0001);
      rd(8'h04, 16'h1F3E, 16'h0002);
      idle(1);
      diag_status_in <= 16'h0000;
      acc(8'h06, 16'h07D6, 16'h0080, 8'h00);
      rd(8'h03, 16'h1F3C, 16'h0000);
      chk({15'h0000, io_warn}, 16'h0000, "warning pin");
      // Watchdog: reads never retrigger, the ack restarts it
      acc(8'h06, 16'h07D0, 16'h00C8, 8'h00);
      acc(8'h06, 16'h2328, 16'h0001, 8'h00);
      repeat (20) rd(8'h03, 16'h2328, 16'h0001);
      // Expiry lands 797..800 cycles after the write; a read retrigger pushes it past 836
      idle(MSC * 185);
      flag(1'b0);
      wait_fail(MSC * 10);
      rd(8'h03, 16'h07D4, 16'h000C);
      rd(8'h03, 16'h1F3C, 16'h0002);
      dchk(16'h0001);
      acc(8'h06, 16'h2328, 16'h0002, 8'h00);
      idle(MSC * 190);
      flag(1'b0);
      wait_fail(MSC * 15);
      acc(8'h06, 16'h07D0, 16'h0000, 8'h00);
      acc(8'h06, 16'h2328, 16'h0000, 8'h00);
      // Connection monitor on one connection
      cid = 3'h2;
      acc(8'h06, 16'h0500, 16'h00C8, 8'h00);
      idle(MSC * 190);
      flag(1'b0);
      wait_fail(MSC * 15);
      rd(8'h03, 16'h07D4, 16'h000D);
      acc(8'h06, 16'h0500, 16'h0000, 8'h00);
      wrap_up();
   end
endmodule
